// ===== src/refmon_switch.sv
// refmon_switch: option register plus the monitor/switch option logic of the clock device.
// assumes reference inputs and the select pin are asynchronous; system clock 100 MHz.
`default_nettype none
module refmon_switch (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire refmon_pkg::bus_req_t bus,             // register port request
   output logic [7:0]                rdata,           // read data, cycle after read strobe
   input  wire logic                 tap_data_out,    // normal test-access-port serial data
   input  wire logic                 tap_data_oe_n,   // normal data-out enable, low drives
   input  wire logic                 main_ref_fail,   // failure interrupt status, same clock
   input  wire logic                 bucket_fail,     // leaky-bucket monitor verdict, same clock
   input  wire logic                 freq_fail,       // frequency monitor verdict, same clock
   input  wire logic [1:0]           auto_chan,       // channel chosen by priority logic, same clock
   input  wire logic                 auto_diff,       // differential chosen by priority logic
   input  wire logic                 ch1_se_prio_nz,  // first single-ended priority nonzero
   input  wire logic                 ch2_se_prio_nz,  // second single-ended priority nonzero
   input  wire logic                 source_select_pin,           // asynchronous pin
   input  wire logic                 first_primary_clock_input,   // asynchronous reference
   input  wire logic                 second_primary_clock_input,  // asynchronous reference
   output logic                      tdo_out,         // data-out pin level
   output logic                      tdo_oe_n,        // data-out enable, low drives
   output logic                      disqualify,      // locked source disqualified
   output var refmon_pkg::sel_t      sel,             // source to lock to
   output logic                      pbo_event,       // one-cycle build-out trigger
   output logic                      phase_hold       // hold present phase relation
);
   // option register and its next value
   logic [7:0]  cfg;
   logic [7:0]  next_cfg;
   logic [7:0]  next_rdata;
   // two-flop synchronisers: stage a feeds only stage b
   logic [2:0]  sync_a;
   logic [2:0]  sync_b;
   logic        miss1;           // gap verdict on first channel
   logic        miss2;           // gap verdict on second channel
   logic        next_tdo_out;
   logic        next_tdo_oe_n;
   logic        next_disqualify;
   refmon_pkg::sel_t next_sel;
   logic        next_pbo_event;
   logic        next_phase_hold;
   logic        fast_miss;

   // register port: write at the decoded address, read answered next cycle
   always_comb begin
      next_cfg   = cfg;
      next_rdata = 8'h00;
      if (bus.wr && bus.addr == refmon_pkg::cfg_addr)
         next_cfg = bus.wdata & refmon_pkg::cfg_used_mask;   // unused bits stay zero
      if (bus.rd && bus.addr == refmon_pkg::cfg_addr)
         next_rdata = cfg;
      // unmapped reads return zero
   end

   // gap watchers, one per primary single-ended reference
   gap_watch u_gap1 (
      .clk      (clk),
      .rst_n    (rst_n),
      .ref_sync (sync_b[0]),
      .missing  (miss1)
   );
   gap_watch u_gap2 (
      .clk      (clk),
      .rst_n    (rst_n),
      .ref_sync (sync_b[1]),
      .missing  (miss2)
   );

   // gap on whichever channel is currently locked to
   assign fast_miss = (sel.chan == 2'h1) ? miss1 : (sel.chan == 2'h2) ? miss2 : 1'b0;

   // option logic
   always_comb begin
      // data-out pin: test port normally, failure mirror when optioned
      if (cfg[refmon_pkg::bit_fail_flag]) begin
         next_tdo_out  = main_ref_fail;
         next_tdo_oe_n = 1'b0;
      end else begin
         next_tdo_out  = tap_data_out;
         next_tdo_oe_n = tap_data_oe_n;
      end
      // slow monitors always count; the gap watcher only when ultra-fast is on
      next_disqualify = bucket_fail | freq_fail;
      if (cfg[refmon_pkg::bit_ultra_fast])
         next_disqualify = next_disqualify | fast_miss;
      // selection: pin-forced pair, else priority logic
      next_sel.forced = cfg[refmon_pkg::bit_ext_switch];
      if (cfg[refmon_pkg::bit_ext_switch]) begin
         if (sync_b[2]) begin
            next_sel.chan = 2'h1;
            next_sel.diff = !ch1_se_prio_nz;
         end else begin
            next_sel.chan = 2'h2;
            next_sel.diff = !ch2_se_prio_nz;
         end
      end else begin
         next_sel.chan = auto_chan;
         next_sel.diff = auto_diff;
      end
      // build-out: one pulse per change of source unless frozen
      next_phase_hold = cfg[refmon_pkg::bit_pbo_freeze];
      next_pbo_event  = cfg[refmon_pkg::bit_pbo_en] && !cfg[refmon_pkg::bit_pbo_freeze]
                        && ({next_sel.chan, next_sel.diff} != {sel.chan, sel.diff});
   end

   // register only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg        <= refmon_pkg::cfg_reset;
         rdata      <= 8'h00;
         sync_a     <= 3'h0;
         sync_b     <= 3'h0;
         tdo_out    <= 1'b0;
         tdo_oe_n   <= 1'b1;
         disqualify <= 1'b0;
         sel        <= '0;
         pbo_event  <= 1'b0;
         phase_hold <= 1'b0;
      end else begin
         cfg        <= next_cfg;
         rdata      <= next_rdata;
         sync_a     <= {source_select_pin, second_primary_clock_input, first_primary_clock_input};
         sync_b     <= sync_a;
         tdo_out    <= next_tdo_out;
         tdo_oe_n   <= next_tdo_oe_n;
         disqualify <= next_disqualify;
         sel        <= next_sel;
         pbo_event  <= next_pbo_event;
         phase_hold <= next_phase_hold;
      end
   end

   // checks: every option output is registered, so each property looks one
   // edge after its cause; pin-driven checks start from the second
   // synchroniser stage and so do not see the two-cycle pin latency
   // limitation: pin pulses shorter than a clock may or may not reach sync_b,
   // so these checks say nothing about glitches on the select pin

   // register port: masked write, read answered once, zero otherwise
   cfg_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.wr && bus.addr == refmon_pkg::cfg_addr)
      |=> (cfg == ($past(bus.wdata) & refmon_pkg::cfg_used_mask)))
      else $error("option write lost");
   read_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
      (bus.rd && bus.addr == refmon_pkg::cfg_addr) |=> (rdata == $past(cfg)))
      else $error("read data wrong");
   read_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(bus.rd && bus.addr == refmon_pkg::cfg_addr) |=> (rdata == 8'h00))
      else $error("read data not cleared");

   // data-out pin: mirror when flagged, test port otherwise
   fail_mirror_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg[refmon_pkg::bit_fail_flag] |=> (tdo_out == $past(main_ref_fail) && !tdo_oe_n))
      else $error("fail flag not mirrored");
   tap_normal_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg[refmon_pkg::bit_fail_flag] |=> (tdo_out == $past(tap_data_out)))
      else $error("data-out not normal");
   tap_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg[refmon_pkg::bit_fail_flag] |=> (tdo_oe_n == $past(tap_data_oe_n)))
      else $error("data-out enable not normal");

   // disqualification: slow monitors always, gap watcher only in ultra-fast
   slow_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!cfg[refmon_pkg::bit_ultra_fast] && !bucket_fail && !freq_fail) |=> !disqualify)
      else $error("spurious disqualify");
   monitor_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      (bucket_fail || freq_fail) |=> disqualify)
      else $error("monitor verdict ignored");
   fast_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg[refmon_pkg::bit_ultra_fast] && fast_miss) |=> disqualify)
      else $error("ultra-fast miss ignored");

   // source selection: pin-forced pair, differential when priority is zero
   ext_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg[refmon_pkg::bit_ext_switch] |=> (sel.chan == 2'h1 || sel.chan == 2'h2))
      else $error("source outside pair");
   forced_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      sel.forced == $past(cfg[refmon_pkg::bit_ext_switch]))
      else $error("forced flag wrong");
   pin_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg[refmon_pkg::bit_ext_switch] && sync_b[2] && ch1_se_prio_nz)
      |=> (sel.chan == 2'h1 && !sel.diff && sel.forced))
      else $error("pin high wrong source");
   pin_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg[refmon_pkg::bit_ext_switch] && !sync_b[2] && ch2_se_prio_nz)
      |=> (sel.chan == 2'h2 && !sel.diff && sel.forced))
      else $error("pin low wrong source");
   diff_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg[refmon_pkg::bit_ext_switch] && sync_b[2] && !ch1_se_prio_nz)
      |=> (sel.chan == 2'h1 && sel.diff))
      else $error("no diff fallback on first");
   diff_fallback_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cfg[refmon_pkg::bit_ext_switch] && !sync_b[2] && !ch2_se_prio_nz)
      |=> (sel.chan == 2'h2 && sel.diff))
      else $error("no diff fallback");

   // phase build-out: the pulse uses the option bits of the cycle before it
   freeze_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      cfg[refmon_pkg::bit_pbo_freeze] |=> (!pbo_event && phase_hold))
      else $error("build-out while frozen");
   hold_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      !cfg[refmon_pkg::bit_pbo_freeze] |=> !phase_hold)
      else $error("phase held while not frozen");
   pbo_change_a: assert property (@(posedge clk) disable iff (!rst_n)
      ($past(cfg[refmon_pkg::bit_pbo_en]) && !$past(cfg[refmon_pkg::bit_pbo_freeze]) && $changed(sel))
      |-> pbo_event)
      else $error("missing build-out event");
   pbo_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      $stable(sel) |-> !pbo_event)
      else $error("build-out without new source");

   // main scenarios
   cov_fast: cover property (@(posedge clk) disable iff (!rst_n)
      cfg[refmon_pkg::bit_ultra_fast] && fast_miss ##1 disqualify);
   cov_pin: cover property (@(posedge clk) disable iff (!rst_n)
      cfg[refmon_pkg::bit_ext_switch] && sel.chan == 2'h2 ##[1:50] sel.chan == 2'h1);
   cov_fallback: cover property (@(posedge clk) disable iff (!rst_n)
      cfg[refmon_pkg::bit_ext_switch] && sel.diff);
   cov_pbo: cover property (@(posedge clk) disable iff (!rst_n) pbo_event);
   cov_mirror: cover property (@(posedge clk) disable iff (!rst_n)
      cfg[refmon_pkg::bit_fail_flag] && main_ref_fail);
endmodule : refmon_switch
`default_nettype wire

// ===== src/refmon_pkg.sv
// refmon_pkg: shared constants and carrier types for the reference monitor / switch options block.
// assumes a single 100 MHz system clock domain.
`default_nettype none
package refmon_pkg;
   // register map (byte address of the option register)
   localparam logic [7:0] cfg_addr       = 8'h48;
   localparam logic [7:0] cfg_reset      = 8'h04;
   // option bit positions
   localparam int         bit_fail_flag  = 6;
   localparam int         bit_ultra_fast = 5;
   localparam int         bit_ext_switch = 4;
   localparam int         bit_pbo_freeze = 3;
   localparam int         bit_pbo_en     = 2;
   localparam logic [7:0] cfg_used_mask  = 8'h7C;
   // ultra-fast: disqualify once one fewer than this many reference cycles have gone missing
   localparam int         missing_limit  = 3;
   // clock rate and gap window (one nominal reference period in clocks)
   localparam int         clk_mhz        = 100;
   localparam logic [15:0] ref_period_clk = 16'h0064;
   // channel codes: 2 bits for the chosen source
   localparam logic [1:0] src_none       = 2'h0;
   localparam logic [1:0] src_ch1_se     = 2'h1;
   localparam logic [1:0] src_ch1_diff   = 2'h2;
   localparam logic [1:0] src_ch2_se     = 2'h3;
   localparam logic [1:0] src_ch2_diff_c = 2'h0;

   // register bus request carrier
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   // source selection result carrier
   typedef struct packed {
      logic [1:0] chan;   // which primary channel (1 or 2 when pin-forced, else the auto_chan value)
      logic       diff;   // 1: differential input of that channel
      logic       forced; // 1: pin-forced choice active
   } sel_t;
endpackage : refmon_pkg
`default_nettype wire

// ===== src/gap_watch.sv
// gap_watch: counts missing reference cycles on one synchronised reference input.
// assumes the input already passed a two-flop synchroniser in the parent.
`default_nettype none
module gap_watch (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ref_sync,  // synchronised reference level
   output logic            missing    // registered: one short of the limit of missing cycles reached
);
   logic        ref_d;       // previous level for edge detect
   logic [15:0] period_cnt;  // clocks since last rising edge or last empty period
   logic [1:0]  miss_cnt;    // whole missing periods
   logic        next_ref_d;
   logic [15:0] next_period_cnt;
   logic [1:0]  next_miss_cnt;
   logic        next_missing;

   // edge resets counters; each empty period counts one missed cycle
   always_comb begin
      next_ref_d      = ref_sync;
      next_period_cnt = period_cnt + 16'h0001;
      next_miss_cnt   = miss_cnt;
      if (ref_sync && !ref_d) begin
         next_period_cnt = 16'h0000;
         next_miss_cnt   = 2'h0;
      end else if (period_cnt >= refmon_pkg::ref_period_clk) begin
         next_period_cnt = 16'h0000;
         // saturate; a reading below the limit keeps counting
         if (miss_cnt != 2'h3)
            next_miss_cnt = miss_cnt + 2'h1;
      end
      // flag before the third missing cycle completes: two already gone
      next_missing = (32'(next_miss_cnt) >= refmon_pkg::missing_limit - 1);
   end

   // register only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_d      <= 1'b0;
         period_cnt <= 16'h0000;
         miss_cnt   <= 2'h0;
         missing    <= 1'b0;
      end else begin
         ref_d      <= next_ref_d;
         period_cnt <= next_period_cnt;
         miss_cnt   <= next_miss_cnt;
         missing    <= next_missing;
      end
   end
endmodule : gap_watch
`default_nettype wire

// ===== test/ref_source_model.sv
// ref_source_model: redundant reference sources and the source-select pin.
// assumes the bench starts and stops each source; period is well under one gap window.
`default_nettype none
module ref_source_model #(
   parameter int half_ns = 200              // half period, 40 clocks a cycle
) (
   input  wire logic run1,                  // first source toggling
   input  wire logic run2,                  // second source toggling
   input  wire logic pin_req,               // wanted select level
   output logic      ref1,                  // first primary reference
   output logic      ref2,                  // second primary reference
   output logic      pin                    // select pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   initial ref1 = 1'b0;
   initial ref2 = 1'b0;
   // a stopped source sticks at its level: that is the loss being modelled
   always #half_ns if (run1) ref1 = ~ref1;
   // second source half period is a quarter longer, so edges line up only every 1000 ns
   always #(half_ns + 50) if (run2) ref2 = ~ref2;
   // pin driven steadily, never floating
   assign pin = pin_req;
endmodule : ref_source_model
`default_nettype wire

// ===== test/test_reference_monitor_switch_options.sv
// test_reference_monitor_switch_options: self-checking bench for refmon_switch.
// assumes ref_source_model drives the references and the select pin.
`default_nettype none
module test_reference_monitor_switch_options;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk = 1'b0;      // 100 MHz
   logic                 rst_n = 1'b0;    // held low at start
   refmon_pkg::bus_req_t bus = '0;        // register request
   logic [7:0]           rdata, d;        // read data, captured value
   logic                 tap_d = 1'b0, tap_oe_n = 1'b1, fail = 1'b0, bucket = 1'b0, freq = 1'b0;
   logic [1:0]           auto_chan = 2'h1; // priority choice
   logic                 auto_diff = 1'b0, nz1 = 1'b1, nz2 = 1'b1, run1 = 1'b1, run2 = 1'b1, pin_req = 1'b0;
   logic                 ref1, ref2, pin, tdo_out, tdo_oe_n, disq, pbo, hold;
   refmon_pkg::sel_t     sel;             // chosen source
   integer               seed = 32'h5d92; // fixed seed
   int                   num_errors = 0;
   int                   checks = 0;
   int                   n;               // bounded wait / pulse count

   always #5 clk = ~clk;

   ref_source_model i_src (.run1(run1), .run2(run2), .pin_req(pin_req), .ref1(ref1), .ref2(ref2), .pin(pin));

   refmon_switch i_dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .tap_data_out(tap_d),
      .tap_data_oe_n(tap_oe_n), .main_ref_fail(fail), .bucket_fail(bucket), .freq_fail(freq),
      .auto_chan(auto_chan), .auto_diff(auto_diff), .ch1_se_prio_nz(nz1), .ch2_se_prio_nz(nz2),
      .source_select_pin(pin), .first_primary_clock_input(ref1), .second_primary_clock_input(ref2),
      .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .disqualify(disq), .sel(sel), .pbo_event(pbo), .phase_hold(hold));

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // one-cycle strobes, released at the next edge
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge clk);
      bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask : wr

   // data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 d = rdata;
   endtask : rd

   // wait k edges, then let their updates settle
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc

   // expected selection word for the chosen mode
   function automatic logic [7:0] exp_sel(input logic ext, pn, a1, a2, input logic [1:0] ac, input logic ad);
      if (!ext) return {4'h0, ac, ad, 1'b0};
      if (pn) return {4'h0, 2'h1, ~a1, 1'b1};
      return {4'h0, 2'h2, ~a2, 1'b1};
   endfunction : exp_sel

   task automatic complete_run;
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      rd(refmon_pkg::cfg_addr);
      chk("cfg reset", d, refmon_pkg::cfg_reset);
      wr(refmon_pkg::cfg_addr, 8'hFF);
      rd(refmon_pkg::cfg_addr);
      chk("cfg used bits", d, refmon_pkg::cfg_used_mask);
      rd(8'h49);
      chk("unmapped read", d, 8'h00);
      // data-out pin in normal and flag mode
      for (int m = 0; m < 2; m++) begin
         wr(refmon_pkg::cfg_addr, m ? 8'h44 : 8'h04);
         repeat (20) begin
            @(posedge clk);
            {tap_d, tap_oe_n, fail} <= 3'($random(seed));
            cyc(1);
            chk("tdo level", tdo_out, m ? fail : tap_d);
            chk("tdo enable", tdo_oe_n, m ? 1'b0 : tap_oe_n);
         end
      end
      // loss of both references, slow then ultra-fast
      for (int u = 0; u < 2; u++) begin
         wr(refmon_pkg::cfg_addr, u ? 8'h24 : 8'h04);
         @(posedge clk);
         run1 <= 1'b1;
         run2 <= 1'b1;
         cyc(400);
         chk("disq running", disq, 1'b0);
         @(posedge clk);
         run1 <= 1'b0;
         run2 <= 1'b0;
         n = 0;
         while (disq !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
         end
         chk("gap disq", disq, u[0]);
         chk("gap disq late", 8'(n < 3 * refmon_pkg::ref_period_clk + 4), u[0]);
         if (u == 1 && n >= 400) complete_run(); // wait bound used up, mismatch already counted
      end
      // ultra-fast off: dead references alone must not disqualify, slow monitors must
      wr(refmon_pkg::cfg_addr, 8'h04);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         {bucket, freq} <= 2'(k);
         cyc(2);
         chk("monitor disq", disq, 8'(k != 0));
      end
      @(posedge clk);
      {bucket, freq} <= 2'b00;
      // pin-forced then priority-logic selection over every pin / priority case, references dead
      for (int x = 0; x < 16; x++) begin
         if (x % 8 == 0) wr(refmon_pkg::cfg_addr, x < 8 ? 8'h14 : 8'h04);
         @(posedge clk);
         {pin_req, nz1, nz2} <= 3'(x);
         auto_chan <= 2'($random(seed));
         auto_diff <= 1'($random(seed));
         cyc(6);
         chk("sel", {4'h0, sel}, exp_sel(x < 8, x[2], x[1], x[0], auto_chan, auto_diff));
      end
      // build-out pulse per new source, none when frozen
      for (int f = 0; f < 2; f++) begin
         wr(refmon_pkg::cfg_addr, f ? 8'h0C : 8'h04);
         cyc(6);
         @(posedge clk);
         auto_chan <= auto_chan + 2'h1;
         n = 0;
         repeat (8) begin
            cyc(1);
            if (pbo === 1'b1) n++;
         end
         chk("pbo count", 8'(n), f ? 8'h00 : 8'h01);
         chk("phase hold", hold, f[0]);
      end
      complete_run();
   end
endmodule : test_reference_monitor_switch_options
`default_nettype wire
